// ===== design/adc_port_pkg.sv
// Constants, field positions and state codes of the converter host port.
package adc_port_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and FIFO geometry.
    localparam int DATA_W = 12;
    localparam int WORD_W = 13;
    localparam int FIFO_DEPTH = 8;
    localparam int FCNT_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // Status/control field positions and value after reset.
    localparam int GATE_BIT = 5;
    localparam int EMPTY_BIT = 4;
    localparam int OOR_BIT = 3;
    localparam logic [11:0] STATUS_RST = 12'h010;
    localparam logic GATE_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TRIG_MIN_PERIODS = 2;
    localparam int CONV_TIME_NS = 7000;
    localparam int CONV_CYCLES_DEF = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////
    // Conversion start sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACK = 4'b0010,
        ST_RISE = 4'b0100,
        ST_CONV = 4'b1000
    } conv_state_e;

endpackage : adc_port_pkg

// ===== design/bit_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module bit_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Asynchronous level in, synchronous level out.
    input wire logic async_i,
    output logic sync_o
);

    logic meta;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule : bit_sync

// ===== design/two_entry_buf.sv
// Two-entry valid/ready buffer for conversion results.
`timescale 1ns/1ps
module two_entry_buf #(
    parameter int W = 13
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Filling side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Draining side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);

    logic [W-1:0] slot0;
    logic [W-1:0] slot1;
    logic [1:0] fill;
    logic next_ready;

    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [1:0] next_fill = fill + {1'b0, push} - {1'b0, pop};

    assign out_valid_o = (fill != 2'h0);
    assign out_data_o = slot0;
    assign next_ready = (next_fill != 2'h2);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fill <= 2'h0;
            in_ready_o <= 1'b1;
        end else begin
            fill <= next_fill;
            in_ready_o <= next_ready;
        end
    end

    // Entry 0 is always the oldest word.
    always_ff @(posedge clk_i) begin
        if (pop) begin
            slot0 <= (push && fill == 2'h1) ? in_data_i : slot1;
        end else if (push && fill == 2'h0) begin
            slot0 <= in_data_i;
        end
        if (push && (fill - {1'b0, pop}) == 2'h1) begin
            slot1 <= in_data_i;
        end
    end

endmodule : two_entry_buf

// ===== design/adc_host_port_busy_ctrl.sv
// Converter host port: start handshake, busy, FIFO and status access.
// Function
// - Sample trigger is accepted asynchronously, with no phase relation.
// - Busy goes low on the clock edge after the trigger is seen low.
// - Trigger rising edge switches track/hold to hold and starts conversion.
// - Busy returns high on the second edge after the trigger is seen high.
// - Chip select and read strobe both low form a read; data is driven.
// - Register select low reads oldest FIFO word, high reads status.
// - Chip select and write strobe low with register select high writes.
// - Internal write pulse is one per access, formed inside the strobes.
// - Output gate bit 0 keeps data drivers off while busy is low.
// - Output gate bit 1 lets data drive while busy is low.
// - Accesses during trigger low proceed; with gate bit 0 bus not driven until busy high.
// - Busy low lasts at most the trigger width plus two periods.
// - After a FIFO read every word shifts down; the count drops unless a new word enters in the same cycle.
// - Output gate bit sits at bit 5 and is readable and writable.
`timescale 1ns/1ps
module adc_host_port_busy_ctrl
    import adc_port_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_DEF,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    // Conversion start handshake.
    input wire logic SAMPLE_TRIGGER_N_I,
    output logic BUSY_N_O,
    output logic HOLD_O,
    output logic CONV_START_O,
    // Host bus.
    input wire logic CS_N_I,
    input wire logic READ_STROBE_N_I,
    input wire logic WRITE_STROBE_N_I,
    input wire logic REGISTER_SELECT_I,
    input wire logic [DATA_W-1:0] WRITE_DATA_I,
    output logic [DATA_W-1:0] DATA_O,
    output logic DATA_OE_O,
    // Conversion results.
    input wire logic RESULT_VALID_I,
    output logic RESULT_READY_O,
    input wire logic [WORD_W-1:0] RESULT_I
);

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int NW = $clog2(DEPTH + 1);
    localparam int IW = $clog2(DEPTH);

    function automatic logic [FCNT_W-1:0] word_count(input logic [NW-1:0] n);
        word_count = (n == '0) ? '0 : FCNT_W'(n - NW'(1));
    endfunction : word_count

    ////////////////////////////////////////////////////////////////////////
    // Trigger synchroniser and start sequencer.
    logic trig_s;
    conv_state_e state;
    conv_state_e next_state;
    logic [CW-1:0] conv_cnt;

    bit_sync #(.RST_VAL(1'b1)) u_trig_sync (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .async_i(SAMPLE_TRIGGER_N_I),
        .sync_o(trig_s)
    );

    wire conv_done = (conv_cnt == CW'(CONV_CYCLES - 1));

    // New triggers are ignored until the conversion finishes.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (!trig_s) next_state = ST_ACK;
            end
            ST_ACK: begin
                if (trig_s) next_state = ST_RISE;
            end
            ST_RISE: begin
                next_state = ST_CONV;
            end
            ST_CONV: begin
                if (conv_done) next_state = ST_IDLE;
            end
        endcase
    end

    wire next_busy_n = !(next_state == ST_ACK || next_state == ST_RISE);
    wire next_hold = (next_state == ST_RISE || next_state == ST_CONV);
    wire next_start = (state == ST_ACK) && trig_s;

    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            state <= ST_IDLE;
            conv_cnt <= '0;
            BUSY_N_O <= 1'b1;
            HOLD_O <= 1'b0;
            CONV_START_O <= 1'b0;
        end else begin
            state <= next_state;
            conv_cnt <= (state == ST_CONV) ? conv_cnt + CW'(1) : '0;
            BUSY_N_O <= next_busy_n;
            HOLD_O <= next_hold;
            CONV_START_O <= next_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host access decode.
    logic gate;
    logic wr_prev;
    logic rd_prev;
    logic rd_sel;

    wire rd_act = !CS_N_I && !READ_STROBE_N_I;
    wire wr_act = !CS_N_I && !WRITE_STROBE_N_I && REGISTER_SELECT_I;
    wire wr_pulse = wr_act && !wr_prev;
    wire next_gate = wr_pulse ? WRITE_DATA_I[GATE_BIT] : gate;
    wire drive_ok = next_busy_n || next_gate;
    wire next_oe = rd_act && drive_ok;

    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            gate <= GATE_RST;
            wr_prev <= 1'b0;
            rd_prev <= 1'b0;
            rd_sel <= 1'b0;
        end else begin
            gate <= next_gate;
            wr_prev <= wr_act;
            rd_prev <= rd_act;
            if (rd_act) rd_sel <= REGISTER_SELECT_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result buffer and shift-down FIFO.
    logic buf_valid;
    logic [WORD_W-1:0] buf_data;
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] next_mem [DEPTH];
    logic [NW-1:0] count;
    logic [NW-1:0] next_count;

    wire fifo_room = (count < NW'(DEPTH));
    wire fifo_push = buf_valid && fifo_room;
    wire fifo_pop = rd_prev && !rd_act && DATA_OE_O && !rd_sel
        && (count != '0);

    two_entry_buf #(.W(WORD_W)) u_result_buf (
        .clk_i(MCLK_I),
        .resetn_i(RESETN_I),
        .in_valid_i(RESULT_VALID_I),
        .in_ready_o(RESULT_READY_O),
        .in_data_i(RESULT_I),
        .out_valid_o(buf_valid),
        .out_ready_i(fifo_room),
        .out_data_o(buf_data)
    );

    always_comb begin
        next_mem = mem;
        next_count = count;
        if (fifo_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_mem[i] = mem[i + 1];
            end
            next_count = count - NW'(1);
        end
        if (fifo_push) begin
            next_mem[next_count[IW-1:0]] = buf_data;
            next_count = next_count + NW'(1);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge MCLK_I) begin
        mem <= next_mem;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path.
    logic [11:0] status;
    wire fifo_empty = (count == '0);

    always_comb begin
        status = STATUS_RST & 12'h000;
        status[GATE_BIT] = gate;
        status[EMPTY_BIT] = fifo_empty;
        status[OOR_BIT] = !fifo_empty && mem[0][WORD_W-1];
        status[FCNT_W-1:0] = word_count(count);
    end

    wire [DATA_W-1:0] rd_word = REGISTER_SELECT_I ? status
        : mem[0][DATA_W-1:0];

    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            DATA_O <= '0;
            DATA_OE_O <= 1'b0;
        end else begin
            if (rd_act) DATA_O <= rd_word;
            DATA_OE_O <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    logic past_valid;

    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) past_valid <= 1'b0;
        else past_valid <= 1'b1;
    end

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RESETN_I);

    AST_BUSY_ACK: assert property (state == ST_IDLE && !trig_s
        |=> !BUSY_N_O && state == ST_ACK)
        else $error("busy not taken low after trigger");
    AST_HOLD_START: assert property (state == ST_ACK && trig_s
        |=> HOLD_O && CONV_START_O ##1 HOLD_O && !CONV_START_O)
        else $error("hold or start pulse wrong at trigger rise");
    AST_BUSY_RELEASE: assert property (state == ST_ACK && trig_s
        |=> !BUSY_N_O ##1 BUSY_N_O)
        else $error("busy not released on second edge");
    AST_BUSY_BOUND: assert property (!BUSY_N_O && trig_s
        |-> ##[1:2] BUSY_N_O)
        else $error("busy held low too long after trigger high");
    AST_SYNC_CAUSE: assert property (past_valid && $fell(BUSY_N_O)
        |-> !$past(trig_s))
        else $error("busy fell without a synchronised trigger");
    AST_GATE_OFF: assert property (!BUSY_N_O && !gate
        |-> !DATA_OE_O)
        else $error("data driven while busy low and gate clear");
    AST_DRIVE_ON: assert property (rd_act
        |=> DATA_OE_O == (BUSY_N_O || gate))
        else $error("read drive enable wrong for busy and gate");
    AST_READ_FIFO: assert property (rd_act && !REGISTER_SELECT_I
        |=> DATA_O == $past(mem[0][DATA_W-1:0]))
        else $error("FIFO read returned wrong word");
    AST_READ_STATUS: assert property (rd_act && REGISTER_SELECT_I
        |=> DATA_O == $past(status))
        else $error("status read returned wrong value");
    AST_WRITE_GATE: assert property (wr_pulse
        |=> gate == $past(WRITE_DATA_I[GATE_BIT]) && !wr_pulse)
        else $error("gate bit not written once per access");
    AST_POP_SHIFT: assert property (fifo_pop && count > NW'(1)
        |=> mem[0] == $past(mem[1]))
        else $error("FIFO did not shift down after read");
    AST_START_PULSE: assert property (CONV_START_O
        |=> !CONV_START_O && HOLD_O)
        else $error("start pulse longer than one cycle");
    AST_CONV_BUSY_HIGH: assert property (state == ST_CONV
        |-> BUSY_N_O)
        else $error("busy low during conversion");
    AST_IDLE_OUTPUTS: assert property (state == ST_IDLE
        |-> BUSY_N_O && !HOLD_O)
        else $error("busy or hold active while idle");
    AST_HOLD_END: assert property (state == ST_CONV && conv_done
        |=> !HOLD_O && state == ST_IDLE)
        else $error("hold not released at end of conversion");
    AST_WRITE_ONLY: assert property (!wr_pulse
        |=> gate == $past(gate))
        else $error("gate bit changed without a register write");
    AST_OE_RELEASE: assert property (!rd_act
        |=> !DATA_OE_O)
        else $error("data driven without a read");
    AST_DATA_STABLE: assert property (!rd_act
        |=> $stable(DATA_O))
        else $error("read data changed without a read");
    AST_POP_COUNT: assert property (fifo_pop && !fifo_push
        |=> count == $past(count) - NW'(1))
        else $error("count not lowered after FIFO read");
    AST_PUSH_COUNT: assert property (fifo_push && !fifo_pop
        |=> count == $past(count) + NW'(1))
        else $error("count not raised after FIFO fill");
    AST_EMPTY_KEEP: assert property (fifo_empty && !fifo_push
        |=> fifo_empty)
        else $error("empty FIFO changed without a new word");

    COV_CONVERSION: cover property (state == ST_ACK ##1 state == ST_RISE
        ##1 state == ST_CONV);
    COV_STRETCHED_READ: cover property (rd_act && !BUSY_N_O && !gate
        ##[1:8] DATA_OE_O);
    COV_FIFO_FULL: cover property (count == NW'(DEPTH) && !RESULT_READY_O);
    COV_GATED_READ: cover property (rd_act && !BUSY_N_O && gate
        ##1 DATA_OE_O);
    COV_GATE_WRITE: cover property (wr_pulse ##1 gate);

endmodule : adc_host_port_busy_ctrl

// ===== sim/host_model.sv
// Host processor model that drives the converter trigger and bus strobes.
`timescale 1ns/1ps
module host_model
    import adc_port_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Converter answers.
    input wire logic busy_n_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic oe_i,
    // Trigger and bus strobes.
    output logic trig_n_o = 1'b1,
    output logic cs_n_o = 1'b1,
    output logic rd_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic rs_o = 1'b0,
    output logic [DATA_W-1:0] wd_o = 12'h000
);

    ////////////////////////////////////////////////////////////////////////
    // Conversion request, never shorter than two clock periods.
    task trig(input int w);
        @(posedge clk_i);
        trig_n_o <= 1'b0;
        repeat ((w < 2) ? 2 : w) @(posedge clk_i);
        trig_n_o <= 1'b1;
    endtask : trig

    ////////////////////////////////////////////////////////////////////////
    // Register write; the strobe goes high again before the next one.
    task wr(input logic rs, input logic [DATA_W-1:0] v);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        wr_n_o <= 1'b0;
        rs_o <= rs;
        wd_o <= v;
        @(posedge clk_i);
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        rs_o <= ~rs;
        wd_o <= ~v;
        repeat (2) @(posedge clk_i);
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    // Read; with stall set the cycle is stretched while busy is low.
    task rd(input logic rs, input logic stall, output logic [DATA_W-1:0] d,
            output logic oe);
        int i;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rd_n_o <= 1'b0;
        rs_o <= rs;
        @(posedge clk_i);
        #1;
        for (i = 0; i < 64 && stall && busy_n_i !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        if (stall) begin
            @(posedge clk_i);
            #1;
        end
        d = data_i;
        oe = oe_i;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        rs_o <= ~rs;
        repeat (2) @(posedge clk_i);
    endtask : rd

endmodule : host_model

// ===== sim/adc_host_port_busy_ctrl_tb_top.sv
// Self-checking testbench of the converter host port.
`timescale 1ns/1ps
module adc_host_port_busy_ctrl_tb_top
    import adc_port_pkg::*;
;
    localparam int CONV = 8;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic trig_n, cs_n, rd_n, wr_n, rs, oe, busy_n, hold, conv_start;
    logic [DATA_W-1:0] wd, data;
    logic res_valid = 1'b0;
    logic res_ready;
    logic [WORD_W-1:0] res = 13'h0000;
    int n_errors = 0;
    int samples_checked = 0;

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    adc_host_port_busy_ctrl #(.CONV_CYCLES(CONV)) i_dut (
        .MCLK_I(mclk), .RESETN_I(resetn), .SAMPLE_TRIGGER_N_I(trig_n),
        .BUSY_N_O(busy_n), .HOLD_O(hold), .CONV_START_O(conv_start),
        .CS_N_I(cs_n), .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n),
        .REGISTER_SELECT_I(rs), .WRITE_DATA_I(wd), .DATA_O(data),
        .DATA_OE_O(oe), .RESULT_VALID_I(res_valid),
        .RESULT_READY_O(res_ready), .RESULT_I(res));

    host_model i_host (
        .clk_i(mclk), .busy_n_i(busy_n), .data_i(data), .oe_i(oe),
        .trig_n_o(trig_n), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .rs_o(rs), .wd_o(wd));

    ////////////////////////////////////////////////////////////////////////
    // Shared checks and helpers.
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [11:0] stat(input logic g, input int c,
                                         input logic oor);
        logic [2:0] f;
        f = (c < 2) ? 3'h0 : 3'(c - 1);
        return {6'h00, g, c == 0, oor, f};
    endfunction : stat

    function automatic logic [12:0] word(input int i);
        return {i == 0, 12'(12'hA00 + i)};
    endfunction : word

    task push(input logic [WORD_W-1:0] w);
        int i;
        @(posedge mclk);
        res_valid <= 1'b1;
        res <= w;
        for (i = 0; i < 32; i++) begin
            @(negedge mclk);
            if (res_ready === 1'b1) break;
        end
        @(posedge mclk);
        res_valid <= 1'b0;
        res <= ~w;
    endtask : push

    task meas(output int nb, nh, ns, no, hf, bl);
        int c;
        nb = 0; nh = 0; ns = 0; no = 0; hf = -1; bl = -2;
        for (c = 0; c < 40; c++) begin
            @(negedge mclk);
            nb += (busy_n === 1'b0);
            nh += (hold === 1'b1);
            ns += (conv_start === 1'b1);
            no += (oe === 1'b1 && busy_n === 1'b0);
            if (busy_n === 1'b0) bl = c;
            if (hold === 1'b1 && hf < 0) hf = c;
        end
    endtask : meas

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task t_reset;
        logic [11:0] d;
        logic o;
        @(negedge mclk);
        chk({busy_n, hold, oe, res_ready}, 16'h0009);
        i_host.rd(1'b1, 1'b1, d, o);
        chk(d, stat(1'b0, 0, 1'b0));
    endtask : t_reset

    task t_conv;
        int w, nb, nh, ns, no, hf, bl;
        for (w = 2; w <= 5; w += 3) begin
            fork
                i_host.trig(w);
                meas(nb, nh, ns, no, hf, bl);
            join
            chk(nb, w + 1);
            chk(hf, bl);
            chk(ns, 1);
            chk(nh >= CONV && nh <= CONV + 1, 1);
        end
    endtask : t_conv

    task t_gate;
        int g, nb, nh, ns, no, hf, bl;
        logic [11:0] d;
        logic o;
        for (g = 0; g < 2; g++) begin
            i_host.wr(1'b1, g[0] ? 12'h020 : 12'h000);
            fork
                i_host.trig(6);
                meas(nb, nh, ns, no, hf, bl);
                begin
                    repeat (3) @(posedge mclk);
                    i_host.rd(1'b1, g == 0, d, o);
                end
            join
            chk(o, 1'b1);
            chk(d, stat(g[0], 0, 1'b0));
            chk(no > 0, g[0]);
        end
        i_host.wr(1'b0, 12'h000);
        i_host.rd(1'b1, 1'b1, d, o);
        chk(d, stat(1'b1, 0, 1'b0));
    endtask : t_gate

    task t_fifo;
        int i;
        logic [11:0] d;
        logic o;
        for (i = 0; i < 10; i++) push(word(i));
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk(res_ready, 1'b0);
        i_host.rd(1'b1, 1'b1, d, o);
        chk(d, stat(1'b1, 8, 1'b1));
        for (i = 0; i < 10; i++) begin
            i_host.rd(1'b0, 1'b1, d, o);
            chk(d, 12'(word(i)));
        end
        i_host.rd(1'b1, 1'b1, d, o);
        chk(d, stat(1'b1, 0, 1'b0));
        i_host.rd(1'b0, 1'b1, d, o);
        chk(d, 12'(word(9)));
    endtask : t_fifo

    ////////////////////////////////////////////////////////////////////////
    // Verdict, main sequence and watchdog.
    task end_of_test;
        $display("Checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_conv;
        t_gate;
        t_fifo;
        end_of_test;
    end

    initial begin
        #200000;
        n_errors++;
        end_of_test;
    end

endmodule : adc_host_port_busy_ctrl_tb_top
